// [dfl_ctrl.sv]
`timescale 1ns/100ps
// Summary of operation
// RULE_01: A sample above the operate threshold drives the output low.
// RULE_02: A sample below the release threshold drives the output high.
// RULE_03: A sample inside the hysteresis band keeps the last output.
// RULE_04: Power-up output may be wrong until a sample beyond a threshold.
// RULE_05: Output is captured at the end of each awake period.
// RULE_06: While asleep the output holds and field changes are ignored.
// RULE_07: Awake length is the same in both internally timed modes.
// RULE_08: Internally timed sleep lasts longer than the awake period.
// RULE_09: Two mode pins decode into internal, external or dual-rate modes.
// RULE_10: Both pins low: awake, then asleep for rest of normal period.
// RULE_11: Internal mode settles, then samples at the end of awake.
// RULE_12: Both pins high: continuously awake, never sleeping.
// RULE_13: Gate high, rate low: asleep, holding the previous sample.
// RULE_14: Host keeps each external awake interval above the minimum.
// RULE_15: Host should wake the device now and then to refresh output.
// RULE_16: Awake and sleep changes follow a rate pin edge after a delay.
// RULE_17: Gate low, rate high selects dual-rate sampling.
// RULE_18: Dual-rate output change switches to fast sleep of eight awakes.
// RULE_19: Dual-rate with no output change for the timeout goes slow.
// RULE_20: Internal awake period lasts 25 microseconds.
// RULE_21: Host keeps each external awake interval at least 46 us.
// RULE_22: Entering dual-rate starts slow with the timeout counter cleared.
module dfl_ctrl #(
  parameter logic [31:0] AWAKE_CYC       = dfl_pkg::AWAKE_CYC,
  parameter logic [31:0] PERIOD_NORM_CYC = dfl_pkg::PERIOD_NORM_CYC,
  parameter logic [31:0] DELAY_EXT_CYC   = dfl_pkg::DELAY_EXT_CYC,
  parameter logic [31:0] PERIOD_SLOW_CYC = dfl_pkg::PERIOD_SLOW_CYC,
  parameter logic [31:0] TIMEOUT_CYC     = dfl_pkg::TIMEOUT_CYC
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic gate_pin_in,
  input  wire logic rate_pin_in,
  input  wire logic above_operate_in,
  input  wire logic below_release_in,
  output logic      latched_output_out,
  output logic      awake_out,
  output logic      fast_rate_out
);

  // =====================================================================
  // Input synchronisation
  // =====================================================================
  logic [dfl_pkg::SYNC_W-1:0] sync_bits;
  logic                       gate_s;
  logic                       rate_s;
  logic                       above_s;
  logic                       below_s;

  dfl_sync u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({gate_pin_in, rate_pin_in,
                  above_operate_in, below_release_in}),
    .sync_out   (sync_bits)
  );

  assign gate_s  = sync_bits[3];
  assign rate_s  = sync_bits[2];
  assign above_s = sync_bits[1];
  assign below_s = sync_bits[0];

  // Pin pair to mode
  function automatic dfl_pkg::dfl_mode_e decode_mode(input logic gate,
                                                     input logic rate);
    decode_mode = dfl_pkg::dfl_mode_e'({gate, rate}); // RULE_09
  endfunction

  // =====================================================================
  // State
  // =====================================================================
  dfl_pkg::dfl_mode_e  mode_ff;
  dfl_pkg::dfl_mode_e  nxt_mode;
  dfl_pkg::dfl_state_e state_ff;
  dfl_pkg::dfl_state_e nxt_state;
  logic [31:0]         cnt_ff;
  logic [31:0]         nxt_cnt;
  logic [31:0]         dly_ff;
  logic [31:0]         nxt_dly;
  logic [31:0]         to_ff;
  logic [31:0]         nxt_to;
  logic                fast_ff;
  logic                nxt_fast;
  logic                lat_ff;
  logic                nxt_lat;
  logic                sample;
  logic                mode_chg;
  logic                restart;
  logic [31:0]         sleep_len;
  dfl_pkg::dfl_mode_e  mode_now;
  logic                want_awake;

  assign mode_now = decode_mode(gate_s, rate_s);
  assign mode_chg = (mode_now != mode_ff);

  // Gate held high: rate pin edges ask for awake or sleep, not a restart,
  // so both directions keep the transition delay
  assign restart  = mode_chg && !(mode_now[1] && mode_ff[1]);

  // Sleep length of the internally timed modes
  always_comb begin
    case (mode_ff)
      dfl_pkg::MODE_NORMAL:
        sleep_len = PERIOD_NORM_CYC - AWAKE_CYC; // RULE_10
      dfl_pkg::MODE_DUAL:
        sleep_len = fast_ff ? dfl_pkg::FAST_SLEEP_MULT * AWAKE_CYC // RULE_18
                            : PERIOD_SLOW_CYC - AWAKE_CYC;
      default:
        sleep_len = PERIOD_NORM_CYC - AWAKE_CYC;
    endcase
  end

  // Sequencer next state; a mode change restarts asleep and slow unless the gate stays high
  always_comb begin
    nxt_mode   = mode_now;
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_dly    = dly_ff;
    sample     = 1'b0;
    want_awake = (mode_ff == dfl_pkg::MODE_EXT_AWAKE);
    if (restart) begin
      nxt_state = dfl_pkg::ST_SLEEP;
      nxt_cnt   = dfl_pkg::CNT_ZERO;
      nxt_dly   = dfl_pkg::CNT_ZERO;
    end else begin
      case (mode_ff)
        dfl_pkg::MODE_NORMAL, dfl_pkg::MODE_DUAL: begin
          if (state_ff == dfl_pkg::ST_AWAKE) begin
            // Settle first, latch on the falling edge of awake
            if (cnt_ff >= AWAKE_CYC - 32'd1) begin // RULE_07 RULE_20
              sample    = 1'b1; // RULE_05 RULE_11
              nxt_state = dfl_pkg::ST_SLEEP;
              nxt_cnt   = dfl_pkg::CNT_ZERO;
            end else begin
              nxt_cnt = cnt_ff + 32'd1;
            end
          end else if (cnt_ff >= sleep_len - 32'd1) begin // RULE_08
            nxt_state = dfl_pkg::ST_AWAKE;
            nxt_cnt   = dfl_pkg::CNT_ZERO;
          end else begin
            nxt_cnt = cnt_ff + 32'd1;
          end
        end
        default: begin
          // External modes; pin level asks, delay counter grants
          if (want_awake != (state_ff == dfl_pkg::ST_AWAKE)) begin
            if (dly_ff >= DELAY_EXT_CYC - 32'd1) begin // RULE_16
              nxt_state = want_awake ? dfl_pkg::ST_AWAKE
                                     : dfl_pkg::ST_SLEEP; // RULE_12 RULE_13
              sample    = !want_awake; // RULE_05
              nxt_dly   = dfl_pkg::CNT_ZERO;
              nxt_cnt   = dfl_pkg::CNT_ZERO;
            end else begin
              nxt_dly = dly_ff + 32'd1;
            end
          end else begin
            nxt_dly = dfl_pkg::CNT_ZERO;
          end
          // Held awake: track the field once settled
          if (state_ff == dfl_pkg::ST_AWAKE && nxt_state == state_ff) begin
            if (cnt_ff >= AWAKE_CYC - 32'd1) begin
              sample = 1'b1; // RULE_12
            end else begin
              nxt_cnt = cnt_ff + 32'd1;
            end
          end
        end
      endcase
    end
  end

  // Latch decision; sleep never samples, so field moves are ignored
  always_comb begin
    nxt_lat = lat_ff; // RULE_03 RULE_06
    if (sample) begin
      if (above_s) begin
        nxt_lat = 1'b0; // RULE_01
      end else if (below_s) begin
        nxt_lat = 1'b1; // RULE_02 RULE_04
      end
    end
  end

  // Dual-rate fast and slow selection
  always_comb begin
    nxt_fast = fast_ff;
    nxt_to   = to_ff;
    if (mode_chg) begin
      nxt_fast = 1'b0; // RULE_22
      nxt_to   = dfl_pkg::CNT_ZERO;
    end else if (mode_ff == dfl_pkg::MODE_DUAL) begin // RULE_17
      if (nxt_lat != lat_ff) begin
        nxt_fast = 1'b1; // RULE_18
        nxt_to   = dfl_pkg::CNT_ZERO;
      end else if (fast_ff) begin
        if (to_ff >= TIMEOUT_CYC - 32'd1) begin
          nxt_fast = 1'b0; // RULE_19
          nxt_to   = dfl_pkg::CNT_ZERO;
        end else begin
          nxt_to = to_ff + 32'd1;
        end
      end
    end
  end

  // Registers; power-up lands in normal mode, asleep and slow
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_ff  <= dfl_pkg::MODE_NORMAL;
      state_ff <= dfl_pkg::ST_SLEEP;
      cnt_ff   <= dfl_pkg::CNT_ZERO;
      dly_ff   <= dfl_pkg::CNT_ZERO;
      to_ff    <= dfl_pkg::CNT_ZERO;
      fast_ff  <= 1'b0; // RULE_22
      lat_ff   <= dfl_pkg::OUT_RST;
    end else begin
      mode_ff  <= nxt_mode;
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      dly_ff   <= nxt_dly;
      to_ff    <= nxt_to;
      fast_ff  <= nxt_fast;
      lat_ff   <= nxt_lat;
    end
  end

  assign latched_output_out = lat_ff;
  assign awake_out          = (state_ff == dfl_pkg::ST_AWAKE);
  assign fast_rate_out      = fast_ff;

  // =====================================================================
  // Assertions
  // =====================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  op_drives_low_a: assert property (sample && above_s |=> !lat_ff) // RULE_01
    else $error("operate sample did not drive output low");
  rp_drives_high_a: assert property ( // RULE_02
    sample && !above_s && below_s |=> lat_ff)
    else $error("release sample did not drive output high");
  band_keeps_a: assert property ( // RULE_03
    sample && !above_s && !below_s |=> $stable(lat_ff))
    else $error("band sample changed output");
  sleep_hold_a: assert property ( // RULE_06
    state_ff == dfl_pkg::ST_SLEEP |=> $stable(lat_ff))
    else $error("output moved while asleep");
  awake_len_a: assert property ( // RULE_07
    $fell(awake_out) && $past(mode_ff) == mode_ff
    && !mode_ff[1] |-> $past(cnt_ff) == AWAKE_CYC - 32'd1)
    else $error("internal awake length wrong");
  sleep_len_a: assert property ( // RULE_08
    $rose(awake_out) && $past(mode_ff) == mode_ff && !mode_ff[1]
    |-> $past(cnt_ff) >= AWAKE_CYC)
    else $error("internal sleep not longer than awake");
  ext_delay_a: assert property ( // RULE_16
    $changed(awake_out) && mode_ff[1] && $past(mode_ff) == mode_ff
    |-> $past(dly_ff) == DELAY_EXT_CYC - 32'd1)
    else $error("external state change without delay");
  fast_on_change_a: assert property ( // RULE_18
    mode_ff == dfl_pkg::MODE_DUAL && !mode_chg && nxt_lat != lat_ff
    |=> fast_ff && to_ff == dfl_pkg::CNT_ZERO)
    else $error("output change did not select fast rate");
  slow_timeout_a: assert property ( // RULE_19
    $fell(fast_ff) && !$past(mode_chg)
    |-> $past(to_ff) == TIMEOUT_CYC - 32'd1)
    else $error("fast rate dropped before timeout");
  dual_entry_a: assert property ( // RULE_22
    restart |=> !fast_ff && to_ff == dfl_pkg::CNT_ZERO && !awake_out)
    else $error("mode entry not slow and cleared");

  normal_cycle_c: cover property (mode_ff == dfl_pkg::MODE_NORMAL
                                  && $fell(awake_out));
  dual_fast_c: cover property ($rose(fast_ff));
  dual_slow_c: cover property ($fell(fast_ff) && !$past(mode_chg));
  ext_wake_c: cover property (mode_ff == dfl_pkg::MODE_EXT_AWAKE
                              && $rose(awake_out));

endmodule // dfl_ctrl

// [dfl_host_model.sv]
`timescale 1ns/100ps
// =====================================================================
// Host model: sets the mode pins, can clock the rate pin itself
// =====================================================================
module dfl_host_model #(
  parameter int HI_CYC = 12,
  parameter int LO_CYC = 16
) (
  input  wire logic       clk_in,
  input  wire logic [1:0] mode_req_in,
  input  wire logic       ext_clk_in,
  output logic            gate_pin_out,
  output logic            rate_pin_out
);
  int cnt;

  // Pins start low so the device powers up in normal mode
  initial begin
    cnt = 0;
    gate_pin_out = 1'b0;
    rate_pin_out = 1'b0;
  end

  // Gated clocking keeps the awake half far above the minimum
  always @(posedge clk_in) begin
    if (ext_clk_in) begin
      gate_pin_out <= 1'b1;
      cnt <= (cnt + 1) % (HI_CYC + LO_CYC);
      rate_pin_out <= (cnt < HI_CYC);
    end else begin
      cnt <= 0;
      gate_pin_out <= mode_req_in[1];
      rate_pin_out <= mode_req_in[0];
    end
  end
endmodule // dfl_host_model

// [dfl_pkg.sv]
// =====================================================================
// Shared constants for the duty-cycled field latch control
// =====================================================================
package dfl_pkg;

  // =====================================================================
  // Clock and timing figures
  // =====================================================================
  localparam logic [31:0] CLK_PERIOD_NS     = 32'h0000_0005; // 200 MHz
  localparam logic [31:0] AWAKE_NS          = 32'h0000_61A8; // 25 us
  localparam logic [31:0] PERIOD_NORM_NS    = 32'h000A_AE60; // 0.7 ms
  localparam logic [31:0] DELAY_EXT_NS      = 32'h0000_61A8; // 25 us
  localparam logic [31:0] PERIOD_SLOW_NS    = 32'h01AB_3F00; // 28 ms
  localparam logic [31:0] TIMEOUT_PERIODS   = 32'h0000_0064; // 100 slow
  localparam logic [31:0] FAST_SLEEP_MULT   = 32'h0000_0008; // x awake

  // Cycle counts derived from the figures above
  localparam logic [31:0] AWAKE_CYC       = AWAKE_NS / CLK_PERIOD_NS;
  localparam logic [31:0] PERIOD_NORM_CYC = PERIOD_NORM_NS / CLK_PERIOD_NS;
  localparam logic [31:0] DELAY_EXT_CYC   = DELAY_EXT_NS / CLK_PERIOD_NS;
  localparam logic [31:0] PERIOD_SLOW_CYC = PERIOD_SLOW_NS / CLK_PERIOD_NS;
  localparam logic [31:0] TIMEOUT_CYC     = TIMEOUT_PERIODS
                                            * PERIOD_SLOW_CYC;

  // =====================================================================
  // Reset values and widths
  // =====================================================================
  localparam logic        OUT_RST   = 1'b1; // Arbitrary; band start is open
  localparam int          SYNC_W    = 4;
  localparam logic [31:0] CNT_ZERO  = 32'h0000_0000;

  // =====================================================================
  // Modes decoded from the gate and rate pins
  // =====================================================================
  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'b00,
    MODE_DUAL      = 2'b01,
    MODE_EXT_SLEEP = 2'b10,
    MODE_EXT_AWAKE = 2'b11
  } dfl_mode_e;

  typedef enum logic {
    ST_SLEEP = 1'b0,
    ST_AWAKE = 1'b1
  } dfl_state_e;

endpackage : dfl_pkg

// [dfl_sync.sv]
`timescale 1ns/100ps
// =====================================================================
// Two-flop synchroniser for asynchronous pin and comparator levels
// =====================================================================
module dfl_sync (
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic [dfl_pkg::SYNC_W-1:0] async_in,
  output logic      [dfl_pkg::SYNC_W-1:0] sync_out
);

  logic [dfl_pkg::SYNC_W-1:0] meta_ff;
  logic [dfl_pkg::SYNC_W-1:0] sync_ff;
  logic [dfl_pkg::SYNC_W-1:0] nxt_meta;
  logic [dfl_pkg::SYNC_W-1:0] nxt_sync;

  // First stage feeds only the second stage
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Registers only
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule // dfl_sync

// [testbench.sv]
`timescale 1ns/100ps
// =====================================================================
// Self-checking bench for the field latch control
// =====================================================================
module testbench;
  logic        clk_in;
  logic        sys_rst_in;
  logic        above_in;
  logic        below_in;
  logic [1:0]  mode_req;
  logic        ext_clk;
  logic        gate_pin;
  logic        rate_pin;
  logic        lat_out;
  logic        awake_out;
  logic        fast_out;
  logic [31:0] n;
  int          mismatches;
  int          n_compared;

  dfl_host_model host_u (
    .clk_in       (clk_in),
    .mode_req_in  (mode_req),
    .ext_clk_in   (ext_clk),
    .gate_pin_out (gate_pin),
    .rate_pin_out (rate_pin)
  );

  // Short counts keep the run well under the cycle budget
  dfl_ctrl #(
    .AWAKE_CYC       (32'h0000_0004),
    .PERIOD_NORM_CYC (32'h0000_0014),
    .DELAY_EXT_CYC   (32'h0000_0003),
    .PERIOD_SLOW_CYC (32'h0000_003C),
    .TIMEOUT_CYC     (32'h0000_012C)
  ) dut_u (
    .clk_in             (clk_in),
    .sys_rst_in         (sys_rst_in),
    .gate_pin_in        (gate_pin),
    .rate_pin_in        (rate_pin),
    .above_operate_in   (above_in),
    .below_release_in   (below_in),
    .latched_output_out (lat_out),
    .awake_out          (awake_out),
    .fast_rate_out      (fast_out)
  );

  // =====================================================================
  // Shared tasks
  // =====================================================================
  task automatic check(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (e !== g) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait on awake level, sampled away from the drive edge
  task automatic wait_lvl(input logic l);
    for (int i = 0; i < 2000 && awake_out !== l; i++) @(negedge clk_in);
  endtask

  task automatic len_of(input logic l, output logic [31:0] c);
    wait_lvl(!l);
    wait_lvl(l);
    c = 0;
    while (awake_out === l && c < 5000) begin
      c++;
      @(negedge clk_in);
    end
  endtask

  task automatic sample_cycle();
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
  endtask

  task automatic set_in(input logic [1:0] m, input logic e, a, b);
    @(posedge clk_in);
    mode_req <= m;
    ext_clk <= e;
    above_in <= a;
    below_in <= b;
  endtask

  // =====================================================================
  // Scenarios
  // =====================================================================
  task automatic test_normal();
    set_in(2'b00, 1'b0, 1'b1, 1'b0);
    len_of(1'b1, n);
    check("awake len", 32'h0000_0004, n);
    len_of(1'b0, n);
    check("sleep len", 32'h0000_0010, n);
    sample_cycle();
    check("out above", 1'b0, lat_out);
    set_in(2'b00, 1'b0, 1'b0, 1'b1);
    repeat (6) @(negedge clk_in);
    check("out asleep", 1'b0, lat_out);
    sample_cycle();
    check("out below", 1'b1, lat_out);
    set_in(2'b00, 1'b0, 1'b0, 1'b0);
    sample_cycle();
    check("out band", 1'b1, lat_out);
    set_in(2'b00, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic test_ext();
    set_in(2'b11, 1'b0, 1'b0, 1'b1);
    repeat (12) @(negedge clk_in);
    n = 0;
    repeat (40) begin
      @(negedge clk_in);
      n = n + awake_out;
    end
    check("awake held", 32'h0000_0028, n);
    set_in(2'b10, 1'b0, 1'b0, 1'b1);
    repeat (20) @(negedge clk_in);
    set_in(2'b10, 1'b0, 1'b1, 1'b0);
    n = 0;
    repeat (40) begin
      @(negedge clk_in);
      n = n + awake_out;
    end
    check("sleep held", 32'h0000_0000, n);
    check("out held", 1'b1, lat_out);
    // Host clocks the rate pin: 12 high, 16 low
    set_in(2'b10, 1'b1, 1'b1, 1'b0);
    len_of(1'b1, n);
    check("ext awake", 32'h0000_000C, n);
    len_of(1'b0, n);
    check("ext sleep", 32'h0000_0010, n);
    check("ext out", 1'b0, lat_out);
    // Wait for a fresh rising edge of the rate pin, not its current level
    while (rate_pin !== 1'b0) @(negedge clk_in);
    while (rate_pin !== 1'b1) @(negedge clk_in);
    n = 0;
    while (awake_out !== 1'b1 && n < 100) begin
      n++;
      @(negedge clk_in);
    end
    // Delay of three, plus two sync stages and the mode register
    check("ext delay", 32'h0000_0006, n);
  endtask

  task automatic test_dual();
    set_in(2'b01, 1'b0, 1'b1, 1'b0);
    len_of(1'b0, n);
    check("slow sleep", 32'h0000_0038, n);
    check("fast start", 1'b0, fast_out);
    set_in(2'b01, 1'b0, 1'b0, 1'b1);
    sample_cycle();
    repeat (2) @(negedge clk_in);
    check("fast set", 1'b1, fast_out);
    len_of(1'b0, n);
    check("fast sleep", 32'h0000_0020, n);
    n = 0;
    while (fast_out === 1'b1 && n < 400) begin
      n++;
      @(negedge clk_in);
    end
    check("fast timeout", 1'b0, fast_out);
    len_of(1'b0, n);
    check("slow again", 32'h0000_0038, n);
  endtask

  // =====================================================================
  // Clock, sequence and watchdog
  // =====================================================================
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Main sequence; reset outputs checked while reset still holds
  initial begin
    mismatches = 0;
    n_compared = 0;
    sys_rst_in = 1'b1;
    above_in = 1'b0;
    below_in = 1'b0;
    mode_req = 2'b00;
    ext_clk = 1'b0;
    repeat (20) @(negedge clk_in);
    check("rst out", 1'b1, lat_out);
    check("rst awake", 1'b0, awake_out);
    check("rst fast", 1'b0, fast_out);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    test_normal();
    test_ext();
    test_dual();
    print_verdict();
  end

  // Tests need about a thousand cycles; cut off well beyond that
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    print_verdict();
  end
endmodule // testbench
